// ---- rtl/rf_signal_source_routing.v ----
`timescale 1ns/1ps
`include "rf_signal_source_routing_regs.vh"
module rf_signal_source_routing #(
  parameter BIT_CLK_DIV = 944
)
(
  input wire mclk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Internal sources
  input wire coderEnvelope,
  input wire txSerial,
  input wire rxSerial,
  input wire rxRegen,
  input wire analogMod,
  input wire compOut,
  input wire rxCarrier,
  input wire rxCarrierUnfilt,
  input wire rxEnvUnfilt,
  input wire testBusBit,
  input wire softPowerDown,
  input wire receiving,
  input wire highSpeed,
  input wire transmitting,
  input wire lastModPulse,
  input wire rxCommand,
  input wire rxInput,
  // Pins
  input wire signalInPin,
  output reg signalOutPin,
  output reg signalOutOe,
  output reg antennaDriverOne,
  output reg antennaDriverTwo,
  output reg antennaDriverOe,
  // Decoder side
  output reg decoderInput,
  output reg decoderInputValid,
  output reg receiverEnable,
  output reg rxInputGated,
  output wire [5:0] guardRemaining
);

  // Register storage
  reg [7:0] txSel_q;
  reg [7:0] rxSel_q;
  // Signal-in synchroniser, three stages
  reg sigIn1_q;
  reg sigIn2_q;
  reg sigIn3_q;
  reg signal_in_pin_q;
  // Bit clock divider
  reg [9:0] div_q;
  wire bitTick;
  // Guard delay state
  localparam GS_IDLE = 2'd0;
  localparam GS_WAIT = 2'd1;
  localparam GS_RX = 2'd2;
  reg [1:0] gState_q;
  reg [1:0] gState_d;
  reg [5:0] gCnt_q;
  reg [5:0] gCnt_d;
  reg txSeen_q;
  // Decoded fields
  wire [1:0] drvSel;
  wire [3:0] sigSel;
  wire [1:0] decSel;
  wire [5:0] guardCycles;
  // Bus decode
  wire wrEn;
  wire hitTx;
  wire hitRx;

  assign drvSel = txSel_q[`TSS_DRV_HI:`TSS_DRV_LO];
  assign sigSel = txSel_q[`TSS_SIG_HI:`TSS_SIG_LO];
  assign decSel = rxSel_q[`RIS_DEC_HI:`RIS_DEC_LO];
  assign guardCycles = rxSel_q[`RIS_WAIT_HI:`RIS_WAIT_LO];
  assign guardRemaining = gCnt_q;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign hitTx = (paddr == `TSS_ADDR);
  assign hitRx = (paddr == `RIS_ADDR);
  assign pslverr = psel & penable & ~(hitTx | hitRx);
  assign wrEn = psel & penable & pwrite;

  // Register writes
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      txSel_q <= `TSS_RESET;
      rxSel_q <= `RIS_RESET;
    end
    else if (wrEn)
    begin
      // Top two bits of transmit select are hardwired zero
      if (hitTx)
        txSel_q <= {2'b00, pwdata[5:0]};
      if (hitRx)
        rxSel_q <= pwdata[7:0];
    end
  end

  // Read mux, bits above the register read zero
  always @*
  begin
    prdata = 32'h00000000;
    if (hitTx)
      prdata = {24'h000000, txSel_q};
    else if (hitRx)
      prdata = {24'h000000, rxSel_q};
  end

  // Signal-in pin synchroniser; a change counts when stages two and three agree
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sigIn1_q <= 1'b0;
      sigIn2_q <= 1'b0;
      sigIn3_q <= 1'b0;
      signal_in_pin_q <= 1'b0;
    end
    else
    begin
      sigIn1_q <= signalInPin;
      sigIn2_q <= sigIn1_q;
      sigIn3_q <= sigIn2_q;
      if (sigIn2_q == sigIn3_q)
        signal_in_pin_q <= sigIn3_q;
    end
  end

  // Bit clock enable divider
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      div_q <= 10'd0;
    else if (bitTick)
      div_q <= 10'd0;
    else
      div_q <= div_q + 10'd1;
  end
  assign bitTick = (div_q == BIT_CLK_DIV[9:0] - 10'd1);

  // Antenna driver routing, registered
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      antennaDriverOne <= 1'b0;
      antennaDriverTwo <= 1'b0;
      antennaDriverOe <= 1'b0;
    end
    else
    begin
      // tristate only by field, power-down alone does not
      antennaDriverOe <= (drvSel != `DRV_TRI);
      case (drvSel)
        `DRV_CODER:
        begin
          antennaDriverOne <= coderEnvelope;
          antennaDriverTwo <= coderEnvelope;
        end
        `DRV_SIGNAL_IN_PIN:
        begin
          antennaDriverOne <= signal_in_pin_q;
          antennaDriverTwo <= signal_in_pin_q;
        end
        `DRV_HIGH:
        begin
          antennaDriverOne <= 1'b1;
          antennaDriverTwo <= 1'b1;
        end
        default:
        begin
          antennaDriverOne <= 1'b0;
          antennaDriverTwo <= 1'b0;
        end
      endcase
    end
  end

  // Signal-out routing, registered
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      signalOutPin <= 1'b0;
      signalOutOe <= 1'b0;
    end
    else
    begin
      signalOutOe <= (sigSel != `SO_TRI);
      case (sigSel)
        `SO_LOW: signalOutPin <= 1'b0;
        `SO_HIGH: signalOutPin <= 1'b1;
        `SO_TEST: signalOutPin <= testBusBit;
        `SO_CODER: signalOutPin <= coderEnvelope;
        `SO_TXSER: signalOutPin <= txSerial;
        `SO_RXSER: signalOutPin <= rxSerial;
        // regenerated card modulation, meaningful while receiving
        `SO_RXREGEN: signalOutPin <= rxRegen & receiving;
        `SO_B_RX: signalOutPin <= rxSerial & receiving;
        `SO_B_COMP: signalOutPin <= compOut;
        `SO_B_RES: signalOutPin <= 1'b0;
        `SO_A_RXC: signalOutPin <= rxCarrier & receiving;
        `SO_A_RXU: signalOutPin <= rxCarrierUnfilt;
        `SO_A_ENV: signalOutPin <= rxEnvUnfilt;
        `SO_B_UNDOC: signalOutPin <= 1'b0;
        `SO_A_UNDOC: signalOutPin <= 1'b0;
        default: signalOutPin <= 1'b0;
      endcase
    end
  end

  // Decoder input routing, registered
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      decoderInput <= 1'b0;
      decoderInputValid <= 1'b1;
    end
    else
    begin
      decoderInputValid <= 1'b1;
      case (decSel)
        `DEC_LOW: decoderInput <= 1'b0;
        `DEC_ENV: decoderInput <= signal_in_pin_q;
        `DEC_ANALOG: decoderInput <= analogMod;
        `DEC_SIGMOD:
        begin
          decoderInput <= signal_in_pin_q;
          decoderInputValid <= highSpeed;
        end
        default: decoderInput <= 1'b0;
      endcase
    end
  end

  // Guard delay next state
  always @*
  begin
    gState_d = gState_q;
    gCnt_d = gCnt_q;
    case (gState_q)
      GS_IDLE:
      begin
        if (rxCommand)
          gState_d = GS_RX;
        else if (txSeen_q && lastModPulse)
        begin
          gCnt_d = guardCycles;
          gState_d = (guardCycles == 6'd0) ? GS_RX : GS_WAIT;
        end
      end
      GS_WAIT:
      begin
        if (bitTick)
        begin
          gCnt_d = gCnt_q - 6'd1;
          if (gCnt_q == 6'd1)
            gState_d = GS_RX;
        end
      end
      GS_RX:
      begin
        // New transmission ends reception
        if (transmitting)
          gState_d = GS_IDLE;
      end
      default:
        gState_d = GS_IDLE;
    endcase
  end

  // Guard delay registers
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      gState_q <= GS_IDLE;
      gCnt_q <= 6'd0;
      txSeen_q <= 1'b0;
    end
    else
    begin
      gState_q <= gState_d;
      gCnt_q <= gCnt_d;
      // Remember a transmission is in progress until its last pulse
      if (transmitting)
        txSeen_q <= 1'b1;
      else if (gState_q == GS_IDLE && lastModPulse)
        txSeen_q <= 1'b0;
    end
  end

  // Receiver enable and gated receive input
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      receiverEnable <= 1'b0;
      rxInputGated <= 1'b0;
    end
    else
    begin
      receiverEnable <= (gState_d == GS_RX);
      rxInputGated <= (gState_d == GS_RX) & rxInput;
    end
  end

endmodule // rf_signal_source_routing

// ---- rtl/rf_signal_source_routing_regs.vh ----
`ifndef RF_SIGNAL_SOURCE_ROUTING_REGS_VH
`define RF_SIGNAL_SOURCE_ROUTING_REGS_VH
// Register indices as printed, byte address is four times the index
`define TSS_INDEX 8'h16
`define RIS_INDEX 8'h17
`define TSS_ADDR 12'h058
`define RIS_ADDR 12'h05c
// Reset values
`define TSS_RESET 8'h10
`define RIS_RESET 8'h84
// Field positions
`define TSS_DRV_HI 5
`define TSS_DRV_LO 4
`define TSS_SIG_HI 3
`define TSS_SIG_LO 0
`define RIS_DEC_HI 7
`define RIS_DEC_LO 6
`define RIS_WAIT_HI 5
`define RIS_WAIT_LO 0
// Antenna driver source codes
`define DRV_TRI 2'h0
`define DRV_CODER 2'h1
`define DRV_SIGNAL_IN_PIN 2'h2
`define DRV_HIGH 2'h3
// Decoder input codes
`define DEC_LOW 2'h0
`define DEC_ENV 2'h1
`define DEC_ANALOG 2'h2
`define DEC_SIGMOD 2'h3
// Signal-out source codes
`define SO_TRI 4'h0
`define SO_LOW 4'h1
`define SO_HIGH 4'h2
`define SO_TEST 4'h3
`define SO_CODER 4'h4
`define SO_TXSER 4'h5
`define SO_RXREGEN 4'h6
`define SO_RXSER 4'h7
`define SO_B_RX 4'h8
`define SO_B_UNDOC 4'h9
`define SO_B_COMP 4'ha
`define SO_B_RES 4'hb
`define SO_A_RXC 4'hc
`define SO_A_UNDOC 4'hd
`define SO_A_RXU 4'he
`define SO_A_ENV 4'hf
// Bit clock: 13.56 MHz carrier over 128 (106 kbit) approximated by divider
`define BITCLK_DIV 10'd944
`endif

// ---- verification/rf_signal_source_routing_props.sv ----
`timescale 1ns/1ps
// Port-level timing relations of the guard and routing logic
module rf_signal_source_routing_props (
  input wire mclk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pslverr,
  input wire antennaDriverOne,
  input wire antennaDriverTwo,
  input wire transmitting,
  input wire lastModPulse,
  input wire receiverEnable,
  input wire rxInputGated,
  input wire [5:0] guardRemaining
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
  property p_same; antennaDriverOne == antennaDriverTwo; endproperty
  a_same: assert property (p_same) else $error("drivers differ");
  property p_tx; transmitting && $past(transmitting) |-> !receiverEnable; endproperty
  a_tx: assert property (p_tx) else $error("receiver on while sending");
  property p_en0; receiverEnable |-> guardRemaining == 6'h00; endproperty
  a_en0: assert property (p_en0) else $error("receiver on before guard end");
  property p_down; guardRemaining != 6'h00 && !lastModPulse |=>
    guardRemaining <= $past(guardRemaining); endproperty
  a_down: assert property (p_down) else $error("guard count grew");
  property p_start; $rose(guardRemaining != 6'h00) |-> $past(lastModPulse); endproperty
  a_start: assert property (p_start) else $error("guard start without pulse");
  property p_gate; rxInputGated |-> receiverEnable || $past(receiverEnable); endproperty
  a_gate: assert property (p_gate) else $error("input passed during guard");
  property p_hold; receiverEnable && !transmitting |=> receiverEnable; endproperty
  a_hold: assert property (p_hold) else $error("receiver dropped");
endmodule // rf_signal_source_routing_props
bind rf_signal_source_routing rf_signal_source_routing_props chk_u (.mclk, .rstn, .psel,
  .penable, .pslverr, .antennaDriverOne, .antennaDriverTwo, .transmitting, .lastModPulse,
  .receiverEnable, .rxInputGated, .guardRemaining);

// ---- verification/rf_signal_source_routing_tb_top.sv ----
`timescale 1ns/1ps
`include "rf_signal_source_routing_regs.vh"
module rf_signal_source_routing_tb_top;
  reg mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, r;
  // Internal sources, one bit each, ordered as idx() expects
  reg [9:0] s = 10'h000;
  reg softPowerDown = 1'h0, receiving = 1'h1, highSpeed = 1'h0, transmitting = 1'h0;
  reg lastModPulse = 1'h0, rxCommand = 1'h0, rxInput = 1'h0, sig = 1'h0, e;
  wire pready, pslverr, signalInPin, signalOutPin, signalOutOe, antennaDriverOne;
  wire antennaDriverTwo, antennaDriverOe, decoderInput, decoderInputValid, receiverEnable;
  wire rxInputGated;
  wire [31:0] prdata;
  wire [5:0] guardRemaining;
  integer miscompares = 0, checked = 0, c, v, n, k;
  // Short bit clock keeps the guard wait brief
  rf_signal_source_routing #(.BIT_CLK_DIV(4)) dut_u (.mclk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .coderEnvelope(s[1]), .txSerial(s[2]),
    .rxSerial(s[4]), .rxRegen(s[3]), .analogMod(s[9]), .compOut(s[5]), .rxCarrier(s[6]),
    .rxCarrierUnfilt(s[7]), .rxEnvUnfilt(s[8]), .testBusBit(s[0]), .softPowerDown, .receiving,
    .highSpeed, .transmitting, .lastModPulse, .rxCommand, .rxInput, .signalInPin, .signalOutPin,
    .signalOutOe, .antennaDriverOne, .antennaDriverTwo, .antennaDriverOe, .decoderInput,
    .decoderInputValid, .receiverEnable, .rxInputGated, .guardRemaining);
  sam_model sam_u (.mclk, .envelope(sig), .pin(signalInPin));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task report_and_stop;
  begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  // Setup, then access until pready; release only after that edge
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
  begin
    apb(1'h0, a, 32'h0);
    chk(r, exp);
  end
  endtask
  // Covers the four-flop signal-in path as well
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  // Signal-out code to source bit, -1 for constants
  function integer idx(input integer c);
  begin
    case (c)
      3, 4, 5, 6, 7: idx = c - 3;
      8: idx = 4;
      10: idx = 5;
      12: idx = 6;
      14: idx = 7;
      15: idx = 8;
      default: idx = -1;
    endcase
  end
  endfunction
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'h1;
    rd(`RIS_ADDR, 32'h84);
    rd(`TSS_ADDR, 32'h10);
    apb(1'h1, `TSS_ADDR, 32'hff);
    rd(`TSS_ADDR, 32'h3f);
    rd(12'h000, 32'h0);
    chk(e, 1);
    for (c = 0; c < 4; c = c + 1)
      for (v = 0; v < 2; v = v + 1)
      begin
        s[1] <= v;
        sig <= !v;
        softPowerDown <= v;
        apb(1'h1, `TSS_ADDR, c << 4);
        settle;
        chk(antennaDriverOe, c != 0);
        if (c != 0)
        begin
          chk(antennaDriverOne, c == 3 ? 1 : (c == 1 ? v : !v));
          chk(antennaDriverTwo, c == 3 ? 1 : (c == 1 ? v : !v));
        end
      end
    // Selected source opposite to all others, so a wrong pick shows
    for (c = 0; c < 16; c = c + 1)
      for (v = 0; v < 2; v = v + 1)
      begin
        k = idx(c);
        s <= (v ? 10'h000 : 10'h3ff) ^ (k >= 0 ? 10'h001 << k : 10'h000);
        apb(1'h1, `TSS_ADDR, 32'h10 | c);
        settle;
        chk(signalOutOe, c != 0);
        if (c != 0)
          chk(signalOutPin, c == 2 || (k >= 0 && v));
      end
    // Gated receive outputs must stay low while not receiving
    receiving <= 1'h0;
    s <= 10'h3ff;
    for (c = 6; c < 13; c = c + 1)
      if (c == 6 || c == 8 || c == 12)
      begin
        apb(1'h1, `TSS_ADDR, 32'h10 | c);
        settle;
        chk(signalOutPin, 0);
      end
    for (c = 0; c < 4; c = c + 1)
      for (v = 0; v < 2; v = v + 1)
      begin
        s[9] <= c == 2 ? v : !v;
        sig <= c == 2 ? !v : v;
        highSpeed <= v;
        apb(1'h1, `RIS_ADDR, (c << 6) | 4);
        settle;
        chk(decoderInput, c != 0 && v);
        chk(decoderInputValid, c != 3 || v);
      end
    apb(1'h1, `RIS_ADDR, 32'h85);
    rd(`RIS_ADDR, 32'h85);
    chk(receiverEnable, 0);
    rxCommand <= 1'h1;
    @(posedge mclk);
    rxCommand <= 1'h0;
    repeat (2) @(posedge mclk);
    chk(receiverEnable, 1);
    rxInput <= 1'h1;
    // Two cycles of sending so the receiver-off check sees a long burst
    transmitting <= 1'h1;
    repeat (2) @(posedge mclk);
    chk(receiverEnable, 0);
    transmitting <= 1'h0;
    lastModPulse <= 1'h1;
    @(posedge mclk);
    lastModPulse <= 1'h0;
    n = 0;
    while (receiverEnable !== 1'h1 && n < 100)
    begin
      @(posedge mclk);
      n = n + 1;
      if (n == 1)
        chk(guardRemaining, 5);
      if (n == 4)
        chk(rxInputGated, 0);
    end
    chk(n >= 17 && n <= 24, 1);
    repeat (2) @(posedge mclk);
    chk(rxInputGated, 1);
    report_and_stop;
  end
endmodule // rf_signal_source_routing_tb_top

// ---- verification/sam_model.sv ----
`timescale 1ns/1ps
// External module, drives the signal-in envelope in step with the clock
module sam_model (
  input wire mclk,
  input wire envelope,
  output reg pin = 1'h0
);
  always @(posedge mclk)
  begin
    pin <= envelope;
  end
endmodule // sam_model
